// ---- shared/rseq_pkg.sv ----
// rseq_pkg: constants, codes and state encodings of the reset sequencer.
// assumes a 50 MHz aclk; all timing figures are converted to cycles here.
package rseq_pkg;

    // clock and time figures
    localparam int CLK_PERIOD_NS = 20;
    localparam int OSC2M_PERIOD_NS = 500;
    localparam int EXT_MIN_PULSE_NS = 1000;
    localparam int BOD_DETECT_NS = 1000;
    // one full 2 MHz period, longest time rounds down
    localparam int WDT_PULSE_CYC = OSC2M_PERIOD_NS / CLK_PERIOD_NS;
    // least times round up
    localparam int EXT_MIN_CYC =
        (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOD_DETECT_CYC =
        (BOD_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYS_DELAY_CYC = 24;
    localparam int SLOW_LONG_CYC = 65536;
    localparam int SLOW_SHORT_CYC = 4096;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [5:0] REG_STATUS_IDX = 6'h00;
    localparam logic [5:0] REG_CTRL_IDX = 6'h01;
    localparam logic [5:0] REG_INFO_IDX = 6'h02;

    // reset cause flag positions
    localparam int FLAG_POR = 0;
    localparam int FLAG_EXT = 1;
    localparam int FLAG_BOR = 2;
    localparam int FLAG_WDT = 3;
    localparam int FLAG_PDI = 4;
    localparam int FLAG_SW = 5;
    localparam logic [5:0] FLAGS_RESET = 6'h01;
    localparam int CTRL_SWRESET_BIT = 0;

    // startup delay fuse codes
    localparam logic [1:0] SUT_LONG = 2'h0;
    localparam logic [1:0] SUT_SHORT = 2'h1;
    localparam logic [1:0] SUT_RSVD = 2'h2;
    localparam logic [1:0] SUT_NONE = 2'h3;

    // brownout mode fuse codes
    localparam logic [1:0] BOD_RSVD = 2'h0;
    localparam logic [1:0] BOD_SAMPLED = 2'h1;
    localparam logic [1:0] BOD_ENABLED = 2'h2;
    localparam logic [1:0] BOD_DISABLED = 2'h3;
    localparam logic [2:0] BOD_LEVEL_LOWEST = 3'h7;

    localparam logic [15:0] RESET_VEC_DEFAULT = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // release sequence states
    typedef enum logic [5:0] {
        ST_HOLD = 6'h01,
        ST_SLOW = 6'h02,
        ST_SYS = 6'h04,
        ST_OSC = 6'h08,
        ST_CAL = 6'h10,
        ST_RUN = 6'h20
    } rseq_state_t;

endpackage

// ---- rtl/rseq_rst_gen.sv ----
// rseq_rst_gen: drives the chip reset and the pin tri-state control.
// assumes hold_req is glitch free (or of flops and clean source levels).
`timescale 1ns/1ps

module rseq_rst_gen
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hold_req,
    input wire logic seq_done,
    output logic sys_rst_n,
    output logic pins_hiz
);

    typedef struct packed {
        logic [1:0] sync;
        logic hiz;
    } rseq_gen_t;

    rseq_gen_t gen_reg;
    rseq_gen_t gen_next;

    // release walks through two flops so downstream never sees a runt edge
    always_comb
    begin
        gen_next = gen_reg;
        gen_next.sync = {gen_reg.sync[0], seq_done};
        gen_next.hiz = ~gen_reg.sync[0];
    end

    // assertion needs no clock: hold_req sets the flops at once
    always_ff @(posedge aclk or posedge hold_req)
    begin
        if (hold_req)
        begin
            gen_reg <= 3'h1;
        end
        else if (!aresetn)
        begin
            gen_reg <= 3'h1;
        end
        else
        begin
            gen_reg <= gen_next;
        end
    end

    assign sys_rst_n = gen_reg.sync[1];
    assign pins_hiz = gen_reg.hiz;

    a_hiz_on_req: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_req |-> pins_hiz && !sys_rst_n)
        else $error("pins not tri-stated during a reset request");

    a_release_sync: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sys_rst_n) |-> $past(seq_done, 2))
        else $error("reset released without two synced cycles");

endmodule // rseq_rst_gen

// ---- rtl/rseq_top.sv ----
// rseq_top: reset source combiner, release sequencer, brownout control
// and the reset status / control registers on an AXI4-Lite slave.
// assumes every input is synchronous to aclk; slow_osc_tick is a one
// cycle pulse per period of the 1 kHz slow oscillator.
//
// How it works
// - any request holds reset until all withdrawn
// - pins tri-stated at once, no clock
// - reset loads vector, peripherals reset, ram kept
// - vector is zero or boot section start
// - release runs delay, osc start, calibration
// - new request restarts the whole release sequence
// - count slow oscillator ticks then 24 clocks
// - startup fuse picks 64K, 4K or none
// - reset selects the 2 MHz default clock
// - start oscillator then load factory calibration
// - per source flags, power-on clears all others
// - continuous brownout resets after detect time
// - sampled brownout checks once per slow tick
// - active fuse awake or idle, sleep fuse otherwise
// - mode fuse: sampled, enabled, disabled, reserved
// - disabled monitor forced on while programming
// - threshold fuse 111 lowest, 000 highest level
// - threshold fuse change waits for programming exit
// - reset pin low past minimum pulse resets
// - watchdog request lasts one 2 MHz period
// - software reset bit resets within two clocks
// - debug port reset only from external debugger
// - software bit self clears; flags write-one-clear
`timescale 1ns/1ps

module rseq_top
    import rseq_pkg::*;
#(
    parameter int SLOW_LONG = SLOW_LONG_CYC,
    parameter int SLOW_SHORT = SLOW_SHORT_CYC,
    parameter logic [15:0] BOOT_VECTOR = 16'h1000
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic por_req,
    input wire logic reset_pin_n,
    input wire logic watchdog_timer_timeout,
    input wire logic program_debug_port_reset,
    input wire logic slow_osc_tick,
    input wire logic vcc_below_trigger,
    input wire logic vcc_above_upper,
    input wire logic [1:0] startup_delay_fuse,
    input wire logic [2:0] brownout_threshold_fuse,
    input wire logic [1:0] brownout_active_mode_fuse,
    input wire logic [1:0] brownout_sleep_mode_fuse,
    input wire logic deep_sleep,
    input wire logic chip_erase,
    input wire logic program_debug_port_enable,
    input wire logic boot_vector_sel,
    input wire logic osc_ready,
    output logic sys_rst_n,
    output logic pins_hiz,
    output logic [15:0] reset_vector,
    output logic clk_default_sel,
    output logic osc_start,
    output logic cal_load,
    output logic brownout_monitor_en,
    output logic [2:0] brownout_level
);

    typedef struct packed {
        rseq_state_t state;
        logic [16:0] cnt;
        logic [7:0] ext_cnt;
        logic ext_req;
        logic [7:0] bod_cnt;
        logic bor_req;
        logic bod_force_cont;
        logic bod_mon_en;
        logic [2:0] bod_fuse_q;
        logic [2:0] bod_level;
        logic [7:0] wdt_cnt;
        logic wdt_req;
        logic sw_req;
        logic [5:0] flags;
        logic clk_sel;
        logic osc_start;
        logic cal_load;
        logic [15:0] vector;
        logic aw_full;
        logic [5:0] aw_idx;
        logic w_full;
        logic [7:0] w_byte;
        logic w_strb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } rseq_regs_t;

    rseq_regs_t rs_reg;
    rseq_regs_t rs_next;
    logic any_req;
    logic [1:0] bod_mode;
    logic bod_cont;
    logic bod_samp;
    logic bod_forced;
    logic sw_wr;
    logic [16:0] slow_last;
    logic [5:0] rd_idx;

    ////////////////////////////////////////////////////////////////////////
    // request combiner: flops and clean levels only, it feeds an async set
    assign any_req = por_req | program_debug_port_reset | rs_reg.ext_req
        | rs_reg.bor_req | rs_reg.wdt_req | rs_reg.sw_req;

    // brownout mode selection and decode
    assign bod_mode = deep_sleep ? brownout_sleep_mode_fuse
        : brownout_active_mode_fuse;
    assign bod_forced = (bod_mode == BOD_DISABLED)
        & (chip_erase | program_debug_port_enable);
    // reserved code is treated as no monitoring
    assign bod_cont = (bod_mode == BOD_ENABLED) | rs_reg.bod_force_cont
        | bod_forced;
    assign bod_samp = (bod_mode == BOD_SAMPLED);

    assign slow_last = (startup_delay_fuse == SUT_SHORT)
        ? 17'(SLOW_SHORT - 1) : 17'(SLOW_LONG - 1);
    assign rd_idx = s_axi_araddr[7:2];
    assign sw_wr = rs_reg.aw_full && rs_reg.w_full && !rs_reg.bvalid
        && rs_reg.aw_idx == REG_CTRL_IDX && rs_reg.w_strb0
        && rs_reg.w_byte[CTRL_SWRESET_BIT];

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb
    begin
        rs_next = rs_reg;
        rs_next.cal_load = 1'b0;

        // release sequencer; any request throws it back to hold
        if (any_req)
        begin
            rs_next.state = ST_HOLD;
            rs_next.cnt = '0;
        end
        else
        begin
            case (rs_reg.state)
                ST_HOLD:
                begin
                    rs_next.cnt = '0;
                    // reserved delay code falls back to the long delay
                    rs_next.state = (startup_delay_fuse == SUT_NONE)
                        ? ST_SYS : ST_SLOW;
                end
                ST_SLOW:
                begin
                    if (slow_osc_tick)
                    begin
                        if (rs_reg.cnt == slow_last)
                        begin
                            rs_next.state = ST_SYS;
                            rs_next.cnt = '0;
                        end
                        else
                        begin
                            rs_next.cnt = rs_reg.cnt + 17'h00001;
                        end
                    end
                end
                ST_SYS:
                begin
                    if (rs_reg.cnt == 17'(SYS_DELAY_CYC - 1))
                    begin
                        rs_next.state = ST_OSC;
                    end
                    else
                    begin
                        rs_next.cnt = rs_reg.cnt + 17'h00001;
                    end
                end
                ST_OSC:
                begin
                    rs_next.osc_start = 1'b1;
                    if (osc_ready)
                    begin
                        rs_next.state = ST_CAL;
                        rs_next.cal_load = 1'b1;
                    end
                end
                ST_CAL:
                begin
                    rs_next.state = ST_RUN;
                end
                ST_RUN:
                begin
                    rs_next.state = ST_RUN;
                end
                default:
                begin
                    rs_next.state = ST_HOLD;
                end
            endcase
        end

        // reset puts the clock system back to its default source
        if (rs_next.state == ST_HOLD)
        begin
            rs_next.clk_sel = 1'b1;
            rs_next.osc_start = 1'b0;
            rs_next.vector = boot_vector_sel ? BOOT_VECTOR
                : RESET_VEC_DEFAULT;
        end
        else if (rs_next.state == ST_RUN)
        begin
            rs_next.clk_sel = 1'b0;
        end

        // reset pin filter: short glitches never reach the combiner
        if (!reset_pin_n)
        begin
            if (rs_reg.ext_cnt != 8'(EXT_MIN_CYC))
            begin
                rs_next.ext_cnt = rs_reg.ext_cnt + 8'h01;
            end
            rs_next.ext_req = (rs_reg.ext_cnt == 8'(EXT_MIN_CYC));
        end
        else
        begin
            rs_next.ext_cnt = '0;
            rs_next.ext_req = 1'b0;
        end

        // watchdog request stretched to one 2 MHz period
        if (rs_reg.wdt_req)
        begin
            rs_next.wdt_cnt = rs_reg.wdt_cnt + 8'h01;
            if (rs_reg.wdt_cnt == 8'(WDT_PULSE_CYC - 1))
            begin
                rs_next.wdt_req = 1'b0;
            end
        end
        else if (watchdog_timer_timeout)
        begin
            rs_next.wdt_req = 1'b1;
            rs_next.wdt_cnt = '0;
        end

        // brownout threshold fuse is frozen while programming
        if (!program_debug_port_enable)
        begin
            rs_next.bod_fuse_q = brownout_threshold_fuse;
        end
        // code order is level order: 111 lowest, 000 highest
        rs_next.bod_level = bod_forced ? BOD_LEVEL_LOWEST
            : rs_next.bod_fuse_q;
        // sampled mode powers the monitor for one cycle per slow tick
        rs_next.bod_mon_en = bod_cont | (bod_samp & slow_osc_tick);

        // brownout detection
        if (bod_cont && vcc_below_trigger)
        begin
            if (rs_reg.bod_cnt != 8'(BOD_DETECT_CYC))
            begin
                rs_next.bod_cnt = rs_reg.bod_cnt + 8'h01;
            end
            else
            begin
                rs_next.bor_req = 1'b1;
            end
        end
        else
        begin
            rs_next.bod_cnt = '0;
        end
        if (bod_samp && rs_reg.bod_mon_en && vcc_below_trigger)
        begin
            rs_next.bor_req = 1'b1;
            rs_next.bod_force_cont = 1'b1;
        end
        // recovery lets the sequencer start its delay
        if (vcc_above_upper && !vcc_below_trigger)
        begin
            rs_next.bor_req = 1'b0;
            rs_next.bod_force_cont = 1'b0;
        end

        // software reset bit lives one cycle: it clears once issued
        if (rs_reg.sw_req)
        begin
            rs_next.sw_req = 1'b0;
        end

        // axi write: address and data taken in either order
        if (s_axi_awvalid && rs_reg.awready)
        begin
            rs_next.aw_full = 1'b1;
            rs_next.aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && rs_reg.wready)
        begin
            rs_next.w_full = 1'b1;
            rs_next.w_byte = s_axi_wdata[7:0];
            rs_next.w_strb0 = s_axi_wstrb[0];
        end
        if (rs_reg.bvalid && s_axi_bready)
        begin
            rs_next.bvalid = 1'b0;
        end
        if (rs_reg.aw_full && rs_reg.w_full && !rs_reg.bvalid)
        begin
            rs_next.aw_full = 1'b0;
            rs_next.w_full = 1'b0;
            rs_next.bvalid = 1'b1;
            rs_next.bresp = RESP_OKAY;
            if (rs_reg.aw_idx == REG_STATUS_IDX && rs_reg.w_strb0)
            begin
                rs_next.flags = rs_reg.flags & ~rs_reg.w_byte[5:0];
            end
            else if (sw_wr)
            begin
                rs_next.sw_req = 1'b1;
            end
            else if (rs_reg.aw_idx > REG_INFO_IDX)
            begin
                rs_next.bresp = RESP_SLVERR;
            end
        end

        // flag setting comes after the clear so a new cause is kept
        rs_next.flags[FLAG_EXT] = rs_next.flags[FLAG_EXT] | rs_reg.ext_req;
        rs_next.flags[FLAG_BOR] = rs_next.flags[FLAG_BOR] | rs_reg.bor_req;
        rs_next.flags[FLAG_WDT] = rs_next.flags[FLAG_WDT] | rs_reg.wdt_req;
        rs_next.flags[FLAG_PDI] = rs_next.flags[FLAG_PDI]
            | program_debug_port_reset;
        rs_next.flags[FLAG_SW] = rs_next.flags[FLAG_SW] | rs_reg.sw_req;
        if (por_req)
        begin
            rs_next.flags = FLAGS_RESET;
        end

        // axi read
        if (rs_reg.rvalid && s_axi_rready)
        begin
            rs_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && rs_reg.arready)
        begin
            rs_next.rvalid = 1'b1;
            rs_next.rresp = RESP_OKAY;
            rs_next.rdata = '0;
            case (rd_idx)
                REG_STATUS_IDX: rs_next.rdata[5:0] = rs_reg.flags;
                REG_CTRL_IDX: rs_next.rdata[0] = rs_reg.sw_req;
                REG_INFO_IDX:
                    rs_next.rdata[7:0] = {bod_cont, bod_samp, rs_reg.state};
                default: rs_next.rresp = RESP_SLVERR;
            endcase
        end
        // one write and one read in flight at a time
        rs_next.awready = !rs_next.aw_full && !rs_next.bvalid;
        rs_next.wready = !rs_next.w_full && !rs_next.bvalid;
        rs_next.arready = !rs_next.rvalid;
    end

    // aresetn is the block's own power-up: sequencer holds, flags show it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rs_reg <= '0;
            rs_reg.state <= ST_HOLD;
            rs_reg.flags <= FLAGS_RESET;
            rs_reg.clk_sel <= 1'b1;
            rs_reg.vector <= RESET_VEC_DEFAULT;
        end
        else
        begin
            rs_reg <= rs_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chip reset and pin control, asserted without a clock
    rseq_rst_gen u_gen
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .hold_req(any_req),
        .seq_done(rs_reg.state == ST_RUN),
        .sys_rst_n(sys_rst_n),
        .pins_hiz(pins_hiz)
    );

    assign s_axi_awready = rs_reg.awready;
    assign s_axi_wready = rs_reg.wready;
    assign s_axi_bvalid = rs_reg.bvalid;
    assign s_axi_bresp = rs_reg.bresp;
    assign s_axi_arready = rs_reg.arready;
    assign s_axi_rvalid = rs_reg.rvalid;
    assign s_axi_rresp = rs_reg.rresp;
    assign s_axi_rdata = rs_reg.rdata;
    assign reset_vector = rs_reg.vector;
    assign clk_default_sel = rs_reg.clk_sel;
    assign osc_start = rs_reg.osc_start;
    assign cal_load = rs_reg.cal_load;
    assign brownout_monitor_en = rs_reg.bod_mon_en;
    assign brownout_level = rs_reg.bod_level;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_hold_in_reset: assert property (any_req |=> !sys_rst_n)
        else $error("request did not hold the chip in reset");
    a_vector_load: assert property ($rose(sys_rst_n) |->
        reset_vector == (boot_vector_sel ? BOOT_VECTOR
        : RESET_VEC_DEFAULT))
        else $error("wrong reset vector at release");
    a_stage_order: assert property ($rose(rs_reg.state == ST_RUN) |->
        $past(rs_reg.state) == ST_CAL)
        else $error("run entered without calibration stage");
    a_seq_restart: assert property ((rs_reg.state != ST_HOLD && any_req)
        |=> rs_reg.state == ST_HOLD)
        else $error("release sequence not restarted");
    a_sys_count: assert property ((rs_reg.state == ST_SYS
        && rs_reg.cnt == 17'(SYS_DELAY_CYC - 1) && !any_req)
        |=> rs_reg.state == ST_OSC ##1 osc_start)
        else $error("system clock tail not 24 cycles");
    a_fuse_bypass: assert property ((rs_reg.state == ST_HOLD && !any_req
        && startup_delay_fuse == SUT_NONE) |=> rs_reg.state == ST_SYS)
        else $error("fuse 11 did not skip the slow delay");
    a_clk_default: assert property (!sys_rst_n && rs_reg.state == ST_HOLD
        |-> ##1 clk_default_sel)
        else $error("default clock not selected in reset");
    a_cal_after_osc: assert property ($rose(cal_load) |->
        $past(osc_ready) && $past(rs_reg.state == ST_OSC))
        else $error("calibration loaded before oscillator ready");
    a_flag_wdt: assert property ((rs_reg.wdt_req && !por_req)
        |=> rs_reg.flags[FLAG_WDT])
        else $error("watchdog flag not set");
    a_bod_force: assert property ((bod_mode == BOD_DISABLED
        && program_debug_port_enable) |=> brownout_monitor_en
        && brownout_level == BOD_LEVEL_LOWEST)
        else $error("brownout monitor not forced on");
    a_wdt_width: assert property ($rose(rs_reg.wdt_req) |->
        ##24 rs_reg.wdt_req ##1 !rs_reg.wdt_req)
        else $error("watchdog request width wrong");
    a_sw_issue: assert property (sw_wr |-> ##[1:2] !sys_rst_n)
        else $error("software reset not issued in two cycles");

endmodule // rseq_top

// ---- verif/rseq_src_model.sv ----
// rseq_src_model: slow oscillator ticks and main oscillator warm-up.
// assumes osc_start stays high from start request until next reset
`timescale 1ns/1ps

module rseq_src_model
(
    input wire logic aclk,
    input wire logic osc_start,
    output logic slow_osc_tick,
    output logic osc_ready
);
    logic [3:0] tick_reg = 4'h0;
    logic [1:0] warm_reg = 2'h0;
    // slow clock runs free; oscillator needs a few cycles before ready
    always @(posedge aclk)
    begin
        tick_reg <= (tick_reg == 4'h9) ? 4'h0 : tick_reg + 4'h1;
        warm_reg <= !osc_start ? 2'h0 : warm_reg + {1'b0, warm_reg != 2'h3};
    end
    assign slow_osc_tick = (tick_reg == 4'h0);
    assign osc_ready = (warm_reg == 2'h3);
endmodule // rseq_src_model

// ---- verif/tb_reset_sequencer.sv ----
// tb_reset_sequencer: drives reset sources and registers, checks flags.
// assumes short slow counts; the model supplies the oscillators
`timescale 1ns/1ps

module tb_reset_sequencer
    import rseq_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, cal_load;
    logic s_axi_arvalid, s_axi_rready, por_req, reset_pin_n, deep_sleep;
    logic watchdog_timer_timeout, program_debug_port_reset, chip_erase;
    logic vcc_below_trigger, vcc_above_upper, program_debug_port_enable;
    logic boot_vector_sel, slow_osc_tick, osc_ready, sys_rst_n, pins_hiz;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, clk_default_sel, osc_start, brownout_monitor_en;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, startup_delay_fuse;
    logic [1:0] brownout_active_mode_fuse, brownout_sleep_mode_fuse;
    logic [2:0] brownout_threshold_fuse, brownout_level;
    logic [15:0] reset_vector;
    logic [33:0] exp_q[$];
    int fails = 0, checks_done = 0, cyc = 0, cals = 0;

    rseq_top #(.SLOW_LONG(8), .SLOW_SHORT(4)) dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .por_req, .reset_pin_n,
        .watchdog_timer_timeout, .program_debug_port_reset, .slow_osc_tick,
        .vcc_below_trigger, .vcc_above_upper, .startup_delay_fuse,
        .brownout_threshold_fuse, .brownout_active_mode_fuse,
        .brownout_sleep_mode_fuse, .deep_sleep, .chip_erase,
        .program_debug_port_enable, .boot_vector_sel, .osc_ready,
        .sys_rst_n, .pins_hiz, .reset_vector, .clk_default_sel, .osc_start,
        .cal_load, .brownout_monitor_en, .brownout_level
    );
    rseq_src_model model (.aclk, .osc_start, .slow_osc_tick, .osc_ready);

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        checks_done++;
        if (seen !== want)
        begin
            fails++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // bus write; both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        exp_q.push_back({RESP_OKAY, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // release must not come sooner than the startup stages allow
    task automatic run_wait(input int mn);
        int n = 0;
        while (sys_rst_n !== 1'b1 && n < 500)
        begin
            @(posedge aclk);
            n++;
        end
        check(34'(n >= mn && n < 500), 34'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // each handed-over answer is matched with the oldest note
    always @(posedge aclk)
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, exp_q.pop_front());
        else if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // cut off a hang; count calibration pulses
    always @(posedge aclk)
    begin
        cals <= cals + cal_load;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            results();
        end
    end

    initial
    begin
        void'($urandom(32'h052b5e9f));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, por_req, deep_sleep} = 4'h0;
        {watchdog_timer_timeout, program_debug_port_reset} = 2'h0;
        {vcc_below_trigger, chip_erase, program_debug_port_enable} = 3'h0;
        {boot_vector_sel, reset_pin_n, vcc_above_upper} = 3'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        startup_delay_fuse = SUT_NONE;
        brownout_active_mode_fuse = BOD_ENABLED;
        brownout_sleep_mode_fuse = BOD_ENABLED;
        brownout_threshold_fuse = 3'($urandom_range(7));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        run_wait(24);
        check({reset_vector, clk_default_sel}, 17'h0);
        check(brownout_level, brownout_threshold_fuse);
        rd(8'h00, {RESP_OKAY, 32'h1});
        rd(8'h0C, {RESP_SLVERR, 32'h0});
        wr(8'h00, 8'h01);
        // pin, brownout, watchdog, debug port, software, power-on
        for (int k = 0; k < 6; k++)
        begin
            case (k)
                0: reset_pin_n <= 1'b0;
                1: {vcc_below_trigger, vcc_above_upper} <= 2'h2;
                2: watchdog_timer_timeout <= 1'b1;
                3: program_debug_port_reset <= 1'b1;
                4: wr(8'h04, 8'h01);
                default: por_req <= 1'b1;
            endcase
            repeat (55) @(posedge aclk);
            if (k != 2 && k != 4)
                check({sys_rst_n, pins_hiz}, 2'h1);
            {reset_pin_n, vcc_above_upper, vcc_below_trigger} <= 3'h6;
            {watchdog_timer_timeout, program_debug_port_reset, por_req} <= 3'h0;
            run_wait(0);
            rd(8'h00, {RESP_OKAY, 24'h0, k == 5 ? 8'h01 : 8'h02 << k});
            wr(8'h00, 8'h3F);
        end
        // a second request mid-sequence restarts the whole delay
        boot_vector_sel <= 1'b1;
        for (int f = 1; f >= 0; f--)
        begin
            startup_delay_fuse <= 2'(f);
            program_debug_port_reset <= 1'b1;
            repeat (20) @(posedge aclk);
            program_debug_port_reset <= 1'b0;
            repeat (20) @(posedge aclk);
            program_debug_port_reset <= 1'b1;
            @(posedge aclk);
            program_debug_port_reset <= 1'b0;
            run_wait(f ? 54 : 94);
        end
        check({reset_vector, osc_start}, 17'h02001);
        brownout_active_mode_fuse <= BOD_DISABLED;
        deep_sleep <= 1'b1;
        repeat (3) @(posedge aclk);
        check(brownout_monitor_en, 1'b1);
        {deep_sleep, chip_erase, program_debug_port_enable} <= 3'h3;
        repeat (3) @(posedge aclk);
        check({brownout_monitor_en, brownout_level}, 4'hF);
        check(34'(cals), 34'h9);
        results();
    end
endmodule // tb_reset_sequencer
